/* verilog/udma_dev.sv */
// Device end: opens a data-in burst and streams words on strobe edges.
`timescale 1ns/1ps
module udma_dev
  import udma_pkg::*;
#(
  parameter int PERIOD_PS = LINK_PS
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [MODE_W-1:0] mode,
  input  wire logic [WORD_W-1:0] in_data,
  input  wire logic              in_valid,
  output logic                   in_ready,
  udma_if.dev                    link
);

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_REQ  = 3'h1,
    D_WAIT = 3'h2,
    D_FIRST = 3'h3,
    D_HOLD = 3'h4,
    D_STEP = 3'h5,
    D_END  = 3'h6
  } dev_state_e;

  dev_state_e        state, next_state;
  logic [WORD_W-1:0] word_hold;
  logic              req;
  logic              ack_s1, ack_s2;
  logic              lrst_s1, lrst_n;
  logic              dmack_n_s1, dmack_n_s2;
  logic              stop_s1, stop_s2;
  logic              rdy_n_s1, rdy_n_s2;
  logic [MODE_W-1:0] mode_s1, mode_s2;
  logic              req_s1, req_s2;
  logic              ack;
  logic              has_word;
  logic [WORD_W-1:0] word_next;
  logic [CNT_W-1:0]  dcnt, ecnt;
  logic              host_go;
  logic              load_word, do_edge;
  logic [CNT_W-1:0]  dvs_cyc, cyc_cyc;
  localparam logic [CNT_W-1:0] ZAD_CYC = cycles_of(T_ZAD_PS, PERIOD_PS);
  localparam logic [CNT_W-1:0] DVH_CYC = cycles_of(T_DVH_PS, PERIOD_PS);

  // User side: the held word stays still until the toggle comes back.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {word_hold, req, in_ready} <= '0;
    end else if (in_valid && in_ready) begin
      word_hold <= in_data;
      req       <= ~req;
      in_ready  <= 1'b0;
    end else if (ack_s2 == req) begin
      in_ready  <= 1'b1;
    end
  end

  // Acknowledge toggle back into the user clock.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
    end
  end

  // Link reset asserts at once and releases on the link clock.
  always_ff @(posedge link.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_s1 <= 1'b0;
      lrst_n  <= 1'b0;
    end else begin
      lrst_s1 <= 1'b1;
      lrst_n  <= lrst_s1;
    end
  end

  // host synchronisers: host lines pass two flops before use.
  always_ff @(posedge link.link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {dmack_n_s1, stop_s1, rdy_n_s1} <= 3'h7;
      {dmack_n_s2, stop_s2, rdy_n_s2} <= 3'h7;
      {mode_s1, mode_s2, req_s1, req_s2} <= '0;
    end else begin
      dmack_n_s1 <= link.dmack_n;
      stop_s1    <= link.stop;
      rdy_n_s1   <= link.hdmardy_n;
      mode_s1    <= mode;
      req_s1     <= req;
      {dmack_n_s2, stop_s2, rdy_n_s2} <= {dmack_n_s1, stop_s1, rdy_n_s1};
      {mode_s2, req_s2}               <= {mode_s1, req_s1};
    end
  end

  // mode counts: per-mode setup and cycle limits in link cycles.
  assign dvs_cyc = cycles_of(T_DVS_PS[mode_idx(mode_s2)], PERIOD_PS);
  assign cyc_cyc = cycles_of(T_CYC_PS[mode_idx(mode_s2)], PERIOD_PS);

  // Link side word slot: filled from the crossing, emptied onto the bus.
  always_ff @(posedge link.link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {has_word, word_next, ack} <= '0;
    end else if (load_word) begin
      has_word  <= 1'b0;
    end else if (!has_word && (req_s2 != ack)) begin
      word_next <= word_hold;
      has_word  <= 1'b1;
      ack       <= req_s2;
    end
  end

  // burst window: host lines count only with request and acknowledge.
  assign host_go = link.dmarq && !dmack_n_s2 && !stop_s2 && !rdy_n_s2;

  // Next state and the word-load and edge decisions.
  always_comb begin
    next_state = state;
    load_word  = 1'b0;
    do_edge    = 1'b0;
    case (state)
      D_IDLE: begin
        if (has_word) begin
          next_state = D_REQ;
        end
      end
      D_REQ: begin
        if (!dmack_n_s2) begin
          next_state = D_WAIT;
        end
      end
      D_WAIT: begin
        // bus turnaround: wait tZAD with all three host conditions.
        if (host_go && dcnt >= ZAD_CYC && has_word) begin
          load_word  = 1'b1;
          next_state = D_FIRST;
        end
      end
      D_FIRST: begin
        // first negation after tDVS on the first word.
        if (dcnt >= dvs_cyc) begin
          do_edge    = 1'b1;
          next_state = D_HOLD;
        end
      end
      D_HOLD: begin
        // data hold before the next word goes out.
        if (stop_s2 || dmack_n_s2) begin
          next_state = D_END;
        end else if (ecnt >= DVH_CYC && has_word && !rdy_n_s2) begin
          load_word  = 1'b1;
          next_state = D_STEP;
        end
      end
      D_STEP: begin
        // pause: no edge while the host shows not ready.
        if (stop_s2 || dmack_n_s2) begin
          next_state = D_END;
        end else if (!rdy_n_s2 && dcnt >= dvs_cyc && ecnt >= cyc_cyc) begin
          do_edge    = 1'b1;
          next_state = D_HOLD;
        end
      end
      D_END: begin
        if (dmack_n_s2) begin
          next_state = D_IDLE;
        end
      end
      default: begin
        next_state = D_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge link.link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      state <= D_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Data age restarts on a load or host wait, edge age on an edge.
  always_ff @(posedge link.link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      {dcnt, ecnt} <= '0;
    end else begin
      if (load_word || (state == D_WAIT && !host_go)) begin
        dcnt <= '0;
      end else if (dcnt != CNT_TOP) begin
        dcnt <= dcnt + 1'b1;
      end
      if (do_edge) begin
        ecnt <= '0;
      end else if (ecnt != CNT_TOP) begin
        ecnt <= ecnt + 1'b1;
      end
    end
  end

  // request: raised with a word, dropped only after the first edge.
  always_ff @(posedge link.link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      link.dmarq <= 1'b0;
    end else if (next_state == D_REQ) begin
      link.dmarq <= 1'b1;
    end else if (next_state == D_END || next_state == D_IDLE) begin
      link.dmarq <= 1'b0;
    end
  end

  // strobe drive: asserted on acknowledge, held driven until released.
  // strobe edges: each edge toggles and carries the word on the bus.
  // spacing: each edge after the first waits tCYC, so like edges sit at least 2 tCYC apart.
  always_ff @(posedge link.link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      link.dstrobe_o  <= 1'b1;
      link.dstrobe_oe <= 1'b0;
    end else if (next_state == D_IDLE) begin
      link.dstrobe_o  <= 1'b1;
      link.dstrobe_oe <= 1'b0;
    end else if (state == D_REQ && next_state == D_WAIT) begin
      link.dstrobe_o  <= 1'b1;
      link.dstrobe_oe <= 1'b1;
    end else if (next_state == D_END) begin
      link.dstrobe_o  <= 1'b1;
    end else if (do_edge) begin
      link.dstrobe_o  <= ~link.dstrobe_o;
    end
  end

  // first word: bus enable and data change together.
  // repeat: each new word loads after the hold has passed.
  always_ff @(posedge link.link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      link.dd_dev_o  <= '0;
      link.dd_dev_oe <= 1'b0;
    end else if (next_state == D_END || next_state == D_IDLE) begin
      link.dd_dev_oe <= 1'b0;
    end else if (load_word) begin
      link.dd_dev_o  <= word_next;
      link.dd_dev_oe <= 1'b1;
    end
  end
endmodule

/* verilog/udma_pkg.sv */
// Shared constants and helpers for the Ultra DMA data-in burst link.
package udma_pkg;

  // Data path and counter widths.
  localparam int WORD_W = 16;
  localparam int MODE_W = 3;
  localparam int CNT_W  = 8;
  localparam logic [MODE_W-1:0] MODE_MAX = 3'h4;
  localparam logic [CNT_W-1:0]  CNT_TOP  = 8'hFF;

  // Clock periods in picoseconds: host side clock and the bench link clock.
  localparam int CLK_PS  = 25000;
  localparam int LINK_PS = 160000;

  // Interval limits in picoseconds.
  localparam int T_ACK_PS = 20000;
  localparam int T_ZAD_PS = 20000;
  localparam int T_RP_PS  = 160000;
  localparam int T_DVH_PS = 9000;
  localparam int T_DVS_PS [5] = '{72900, 50900, 33900, 22600, 9500};
  localparam int T_CYC_PS [5] = '{120000, 90000, 60000, 45000, 30000};

  // Bus level shown by a released line, held up by the pull-ups.
  localparam logic [WORD_W-1:0] BUS_IDLE = 16'hFFFF;

  // A least time rounded up to whole cycles, never below one cycle.
  function automatic logic [CNT_W-1:0] cycles_of(input int ps,
                                                 input int per);
    int c;
    c = (ps + per - 1) / per;
    if (c < 1) begin
      c = 1;
    end
    if (c > int'(CNT_TOP)) begin
      c = int'(CNT_TOP);
    end
    return CNT_W'(c);
  endfunction

  // Modes above the highest one fall back to the highest.
  function automatic int mode_idx(input logic [MODE_W-1:0] m);
    int i;
    i = (m > MODE_MAX) ? int'(MODE_MAX) : int'(m);
    return i;
  endfunction

endpackage

/* verilog/udma_if.sv */
// Link wires between the host controller and the device during a burst.
`timescale 1ns/1ps
interface udma_if;
  import udma_pkg::*;

  logic              link_clk;
  logic              dmarq;
  logic              dstrobe_o;
  logic              dstrobe_oe;
  logic [WORD_W-1:0] dd_dev_o;
  logic              dd_dev_oe;
  logic              dmack_n;
  logic              stop;
  logic              hdmardy_n;
  logic [WORD_W-1:0] dd_host_o;
  logic              dd_host_oe;
  logic              dstrobe;
  logic [WORD_W-1:0] dd;

  // Released lines read high through the host pull-ups.
  assign dstrobe = dstrobe_oe ? dstrobe_o : 1'b1;
  assign dd      = dd_dev_oe ? dd_dev_o : (dd_host_oe ? dd_host_o : BUS_IDLE);

  modport dev (
    input  link_clk,
    input  dmack_n,
    input  stop,
    input  hdmardy_n,
    output dmarq,
    output dstrobe_o,
    output dstrobe_oe,
    output dd_dev_o,
    output dd_dev_oe
  );

  modport host (
    input  dmarq,
    input  dstrobe,
    input  dd,
    output dmack_n,
    output stop,
    output hdmardy_n,
    output dd_host_o,
    output dd_host_oe
  );
endinterface

/* verilog/udma_host.sv */
// Host end: accepts a data-in burst and delivers each strobed word.
`timescale 1ns/1ps
module udma_host
  import udma_pkg::*;
#(
  parameter int PERIOD_PS = CLK_PS
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              hold,
  input  wire logic              finish,
  output logic [WORD_W-1:0]      out_data,
  output logic                   out_valid,
  output logic                   active,
  udma_if.host                   link
);

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_ACK  = 3'h1,
    H_ENV  = 3'h2,
    H_RUN  = 3'h3,
    H_STOP = 3'h4,
    H_DONE = 3'h5
  } host_state_e;

  localparam logic [CNT_W-1:0] ACK_CYC = cycles_of(T_ACK_PS, PERIOD_PS);
  localparam logic [CNT_W-1:0] RP_CYC  = cycles_of(T_RP_PS, PERIOD_PS);

  host_state_e       state;
  logic [CNT_W-1:0]  cnt;
  logic              dmarq_s1;
  logic              dmarq_s2;
  logic              strb_s1;
  logic              strb_s2;
  logic              strb_q;
  logic [WORD_W-1:0] dd_s1;
  logic [WORD_W-1:0] dd_s2;
  logic              armed;
  logic              got_first;
  logic              edge_ok;

  // Device lines cross from the link clock through two flops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dmarq_s1 <= 1'b0;
      dmarq_s2 <= 1'b0;
      strb_s1  <= 1'b1;
      strb_s2  <= 1'b1;
      strb_q   <= 1'b1;
      dd_s1    <= '0;
      dd_s2    <= '0;
    end else begin
      dmarq_s1 <= link.dmarq;
      dmarq_s2 <= dmarq_s1;
      strb_s1  <= link.dstrobe;
      strb_s2  <= strb_s1;
      strb_q   <= strb_s2;
      dd_s1    <= link.dd;
      dd_s2    <= dd_s1;
    end
  end

  // data edges count only inside the request window and before STOP.
  assign edge_ok = armed && (strb_s2 != strb_q) && dmarq_s2 &&
                   !link.dmack_n && (state == H_RUN || state == H_STOP);

  // Arm on a high strobe inside the burst; the first edge is a negation.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      armed     <= 1'b0;
      got_first <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= edge_ok;
      if (edge_ok) begin
        out_data  <= dd_s2;
        got_first <= 1'b1;
      end else if (state == H_IDLE) begin
        got_first <= 1'b0;
      end
      if (state == H_IDLE) begin
        armed <= 1'b0;
      end else if (state == H_RUN && strb_s2) begin
        armed <= 1'b1;
      end
    end
  end

  // Burst sequencer with a shared interval counter.
  // idle: acknowledge negated, STOP asserted, not ready, bus driven.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state           <= H_IDLE;
      cnt             <= '0;
      link.dmack_n    <= 1'b1;
      link.stop       <= 1'b1;
      link.hdmardy_n  <= 1'b1;
      link.dd_host_o  <= '0;
      link.dd_host_oe <= 1'b1;
      active          <= 1'b0;
    end else begin
      cnt <= (cnt != CNT_TOP) ? cnt + 1'b1 : cnt;
      case (state)
        H_IDLE: begin
          // setup: STOP and not-ready already stand before acknowledge.
          link.stop       <= 1'b1;
          link.hdmardy_n  <= 1'b1;
          link.dd_host_oe <= 1'b1;
          cnt             <= '0;
          if (enable && dmarq_s2) begin
            state <= H_ACK;
          end
        end
        H_ACK: begin
          // acknowledge after tACK; bus released with it.
          if (cnt >= ACK_CYC) begin
            link.dmack_n    <= 1'b0;
            link.dd_host_oe <= 1'b0;
            active          <= 1'b1;
            cnt             <= '0;
            state           <= H_ENV;
          end
        end
        H_ENV: begin
          // acknowledge setup, then STOP off and ready inside tENV.
          if (cnt >= ACK_CYC) begin
            link.stop      <= 1'b0;
            link.hdmardy_n <= 1'b0;
            state          <= H_RUN;
          end
        end
        H_RUN: begin
          // no change of STOP or ready before the first word.
          if (got_first && finish) begin
            link.hdmardy_n <= 1'b1;
            cnt            <= '0;
            state          <= H_STOP;
          end else if (got_first) begin
            link.hdmardy_n <= hold;
          end
        end
        H_STOP: begin
          // Not ready for tRP, then STOP asks the device to end.
          if (cnt >= RP_CYC) begin
            link.stop <= 1'b1;
            cnt       <= '0;
            state     <= H_DONE;
          end
        end
        H_DONE: begin
          // acknowledge hold: tACK after the request drops.
          if (dmarq_s2) begin
            cnt <= '0;
          end else if (cnt >= ACK_CYC) begin
            link.dmack_n <= 1'b1;
            active       <= 1'b0;
            cnt          <= '0;
            state        <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule

/* tb/udma_burst_properties.sv */
// Concurrent checks on the device side of the burst link.
`timescale 1ns/1ps
module udma_burst_properties
  import udma_pkg::*;
(
  input wire logic              link_clk,
  input wire logic              rst_n,
  input wire logic              dmarq,
  input wire logic              dstrobe,
  input wire logic              dstrobe_oe,
  input wire logic [WORD_W-1:0] dd,
  input wire logic              dd_dev_oe,
  input wire logic              dmack_n,
  input wire logic              stop,
  input wire logic              hdmardy_n
);
  logic strb_q;
  logic fell_seen;

  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!rst_n);

  // Notes the first strobe negation; cleared once acknowledge drops.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      strb_q    <= 1'b1;
      fell_seen <= 1'b0;
    end else begin
      strb_q    <= dstrobe;
      fell_seen <= !dmack_n && (fell_seen || (strb_q && !dstrobe));
    end
  end

  property p_req_held;
    $fell(dmarq) |-> fell_seen || $fell(dstrobe);
  endproperty
  a_req_held: assert property (p_req_held)
    else $error("Request dropped before the first strobe fall.");

  property p_strb_keep;
    dstrobe_oe && !dmack_n |=> dstrobe_oe;
  endproperty
  a_strb_keep: assert property (p_strb_keep)
    else $error("Strobe released while acknowledged.");

  property p_sync_delay;
    $fell(dmack_n) |-> !dstrobe_oe ##1 !dstrobe_oe;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Strobe driven before acknowledge was synchronised.");

  property p_bus_wait;
    $rose(dd_dev_oe) |-> $past(!dmack_n && !stop && !hdmardy_n, 2);
  endproperty
  a_bus_wait: assert property (p_bus_wait)
    else $error("Data bus driven before host conditions held.");

  property p_first_setup;
    $fell(dstrobe) && !fell_seen |-> dd_dev_oe && $past(dd_dev_oe)
      && $stable(dd);
  endproperty
  a_first_setup: assert property (p_first_setup)
    else $error("First strobe fall without settled first word.");

  property p_setup;
    $changed(dstrobe) && dmarq |-> $stable(dd);
  endproperty
  a_setup: assert property (p_setup)
    else $error("Data changed in the cycle of a strobe edge.");

  property p_hold;
    $changed(dstrobe) && dmarq |=> $stable(dd) || !dmarq;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Data changed right after a strobe edge.");

  property p_spacing;
    $changed(dstrobe) && dmarq |=> $stable(dstrobe) || !dmarq;
  endproperty
  a_spacing: assert property (p_spacing)
    else $error("Strobe edges in adjacent link cycles.");

  property p_pause;
    hdmardy_n [*5] ##0 dmarq |-> $stable(dstrobe);
  endproperty
  a_pause: assert property (p_pause)
    else $error("Strobe edge while host not ready.");

  property p_idle_release;
    dmack_n [*5] |-> !dstrobe_oe && !dd_dev_oe;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("Link lines driven without acknowledge.");

  c_first: cover property ($fell(dstrobe) && !fell_seen);
  c_pause: cover property (hdmardy_n [*5] ##0 dmarq);
  c_end:   cover property ($fell(dmarq));
endmodule

/* tb/udma_data_in_burst_start_tb_top.sv */
// Bench joining the device and host ends across one link.
`timescale 1ns/1ps
module udma_data_in_burst_start_tb_top;
  import udma_pkg::*;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [WORD_W-1:0] word;
  } row_s;

  logic              clock;
  logic              rst_n;
  logic [MODE_W-1:0] mode;
  logic [WORD_W-1:0] in_data;
  logic              in_valid;
  logic              in_ready;
  logic              enable;
  logic              hold;
  logic              finish;
  logic [WORD_W-1:0] out_data;
  logic              out_valid;
  logic              active;
  int                fails;
  int                tests_run;
  int                cycles;
  logic [WORD_W-1:0] got[$];
  row_s              rows[6];

  udma_if i_udma_if ();
  udma_dev #(.PERIOD_PS(LINK_PS)) i_udma_dev (.clock(clock),
    .rst_n(rst_n), .mode(mode), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .link(i_udma_if.dev));
  udma_host #(.PERIOD_PS(CLK_PS)) i_udma_host (.clock(clock),
    .rst_n(rst_n), .enable(enable), .hold(hold), .finish(finish),
    .out_data(out_data), .out_valid(out_valid), .active(active),
    .link(i_udma_if.host));
  udma_burst_properties i_udma_burst_properties (
    .link_clk(i_udma_if.link_clk), .rst_n(rst_n),
    .dmarq(i_udma_if.dmarq), .dstrobe(i_udma_if.dstrobe),
    .dstrobe_oe(i_udma_if.dstrobe_oe), .dd(i_udma_if.dd),
    .dd_dev_oe(i_udma_if.dd_dev_oe), .dmack_n(i_udma_if.dmack_n),
    .stop(i_udma_if.stop), .hdmardy_n(i_udma_if.hdmardy_n));

  // User clock; the link clock has an odd offset so phases never align.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    i_udma_if.link_clk = 1'b0;
    #7;
    forever #80 i_udma_if.link_clk = ~i_udma_if.link_clk;
  end

  // Collects words at the falling edge, clear of the launching edge.
  always @(negedge clock) begin
    if (out_valid === 1'b1) got.push_back(out_data);
    cycles++;
    if (cycles == 40000) begin
      fails++;
      stop_test();
    end
  end

  task automatic check(input logic [WORD_W-1:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [WORD_W-1:0] w);
    int n;
    n = 0;
    while (in_ready !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    in_data  = w;
    in_valid = 1'b1;
    @(negedge clock);
    in_valid = 1'b0;
  endtask

  // Gives up after a bounded wait so a lost word is a mismatch.
  task automatic expect_word(input logic [WORD_W-1:0] w);
    int n;
    n = 0;
    while (got.size() == 0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    check(got.size() > 0 ? got.pop_front() : ~w, w);
  endtask

  task automatic check_idle();
    check(i_udma_if.dmarq, 1'b0);
    check(i_udma_if.dstrobe_oe, 1'b0);
    check(i_udma_if.dd_dev_oe, 1'b0);
    check(i_udma_if.dmack_n, 1'b1);
    check(i_udma_if.stop, 1'b1);
    check(i_udma_if.hdmardy_n, 1'b1);
    check(in_ready, 1'b0);
    check(active, 1'b0);
  endtask

  task automatic end_test(input string name);
    $display("Test %s done, mismatches so far %0d", name, fails);
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    rst_n    = 1'b0;
    mode     = 3'h4;
    in_data  = 16'h0000;
    in_valid = 1'b0;
    enable   = 1'b0;
    hold     = 1'b0;
    finish   = 1'b0;
    rows = '{'{3'h0, 16'h0001}, '{3'h1, 16'h8000}, '{3'h2, 16'hFFFF},
             '{3'h3, 16'h0000}, '{3'h4, 16'h1234}, '{3'h7, 16'hEDCB}};
    repeat (8) @(negedge clock);
    check_idle();
    rst_n = 1'b1;
    end_test("reset");
    // request waits for an acknowledge that is withheld.
    send(16'hC33C);
    repeat (80) @(negedge clock);
    check(i_udma_if.dmarq, 1'b1);
    check(i_udma_if.dmack_n, 1'b1);
    enable = 1'b1;
    expect_word(16'hC33C);
    check(active, 1'b1);
    check(i_udma_if.stop, 1'b0);
    end_test("start");
    // Ordinary words through every mode, one row each.
    foreach (rows[i]) begin
      mode = rows[i].mode;
      send(rows[i].word);
      expect_word(rows[i].word);
    end
    end_test("modes");
    send(16'h1111);
    send(16'h2222);
    send(16'h3333);
    expect_word(16'h1111);
    expect_word(16'h2222);
    expect_word(16'h3333);
    end_test("stream");
    // a paused host receives nothing until it is ready again.
    hold = 1'b1;
    repeat (60) @(negedge clock);
    send(16'hA5A5);
    repeat (200) @(negedge clock);
    check(WORD_W'(got.size()), 16'h0000);
    hold = 1'b0;
    expect_word(16'hA5A5);
    end_test("pause");
    // host ends the burst; a fresh burst opens afterwards.
    finish = 1'b1;
    repeat (300) @(negedge clock);
    check(active, 1'b0);
    check(i_udma_if.dstrobe_oe, 1'b0);
    check(i_udma_if.dd_dev_oe, 1'b0);
    finish = 1'b0;
    send(16'h5A5A);
    expect_word(16'h5A5A);
    end_test("finish");
    // Reset in mid-burst returns every line to idle.
    send(16'h0F0F);
    repeat (30) @(negedge clock);
    rst_n = 1'b0;
    repeat (8) @(negedge clock);
    check_idle();
    got.delete();
    rst_n = 1'b1;
    send(16'hF0F0);
    expect_word(16'hF0F0);
    end_test("midreset");
    stop_test();
  end
endmodule
